// ===== ascdh_top.v
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "ascdh_map.vh"

module ascdh_top (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [4:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output wire [1:0] master_clock_out_o,
  input wire [1:0] bit_clock_pin_i,
  output wire [1:0] bit_clock_pin_o,
  output wire [1:0] bit_clock_pin_oe_n_o,
  input wire [1:0] frame_sync_pin_i,
  output wire [1:0] frame_sync_pin_o,
  output wire [1:0] frame_sync_pin_oe_n_o,
  output reg tx_data_o,
  input wire rx_data_i
);

  // ==========================================
  // Helpers
  function [5:0] wlen;
    input [2:0] k;
    begin
      case (k)
        3'h0: wlen = 6'h20;
        3'h1: wlen = 6'h18;
        3'h2: wlen = 6'h14;
        3'h3: wlen = 6'h12;
        3'h4: wlen = 6'h10;
        3'h5: wlen = 6'h10;
        default: wlen = 6'h08;
      endcase
    end
  endfunction

  function [31:0] setb;
    input [31:0] w;
    input [5:0] i;
    input b;
    begin
      setb = w;
      setb[i[4:0]] = b;
    end
  endfunction

  // ==========================================
  // Registers
  reg [31:0] ctrl_q;
  reg [31:0] cu0_q;
  reg [31:0] cu1_q;
  reg [31:0] txc_q;
  reg [31:0] rxc_q;
  reg [31:0] txh_q;
  reg [31:0] rxh_q;
  reg [31:0] tw_q;
  reg [31:0] rs_q;
  reg [31:0] rlo_q;
  reg [31:0] last_q [0:7];
  reg txfull_q;
  reg rxrdy_q;
  reg rxor_q;
  reg txur_q;
  reg r1_q;
  reg r2_q;
  reg [31:0] rdata_d;
  integer i;

  wire [1:0] mode = ctrl_q[`ASCDH_MODE];
  wire mst = mode != `ASCDH_M_SLAVE;
  wire ctl = mode == `ASCDH_M_CTRL;
  wire wr_flag = reg_wr_i & (reg_addr_i == `ASCDH_A_FLAG);
  wire wr_txd = reg_wr_i & (reg_addr_i == `ASCDH_A_TXD);
  wire rd_rxd = reg_rd_i & (reg_addr_i == `ASCDH_A_RXD);

  wire [1:0] rise_w;
  wire [1:0] fall_w;
  wire [5:0] ds_w;
  wire [5:0] nds_w;
  wire [9:0] db_w;
  wire [9:0] ndb_w;
  wire [11:0] sb_w;

  // ==========================================
  // Clock units
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : cu
      wire [31:0] c = (g == 0) ? cu0_q : cu1_q;
      wire en = ctrl_q[`ASCDH_CKEN0 + g];
      wire [7:0] od = c[`ASCDH_ODIV];
      wire [7:0] bd = (c[`ASCDH_BDIV] == 8'h00) ? 8'h01 : c[`ASCDH_BDIV];
      wire [8:0] hp = {1'b0, bd} + 9'h001;
      wire [7:0] h = hp[8:1];
      wire [5:0] sb = {({1'b0, c[`ASCDH_SLSZ]} + 3'h1), 3'h0};
      wire [3:0] ns = {1'b0, c[`ASCDH_NSLOT]} + 4'h1;
      wire [9:0] tot = {6'h00, ns} * {4'h0, sb};
      reg [7:0] mc_q;
      reg mck_q;
      reg [7:0] bc_q;
      reg sck_q;
      reg [2:0] ds_q;
      reg [4:0] db_q;
      reg fs_q;
      reg fsp_q;
      reg k1_q;
      reg k2_q;
      reg k3_q;
      reg f1_q;
      reg f2_q;
      wire mt = mc_q >= od;
      wire [7:0] nmc = mt ? 8'h00 : mc_q + 8'h01;
      wire bt = (c[`ASCDH_MASTER_CLOCK_SOURCE_SELECT] | c[`ASCDH_BIT_CLOCK_SOURCE_SELECT]) ? mt : 1'b1;
      wire rs = mst ? (bt & (bc_q == 8'h00)) : (k2_q & ~k3_q);
      wire fl = mst ? (bt & (bc_q == h)) : (~k2_q & k3_q);
      wire rise = en & rs;
      wire fall = en & fl;
      wire lb = {1'b0, db_q} == sb - 6'h01;
      wire ls = {1'b0, ds_q} == ns - 4'h1;
      wire [4:0] ndb = lb ? 5'h00 : db_q + 5'h01;
      wire [2:0] nds = lb ? (ls ? 3'h0 : ds_q + 3'h1) : ds_q;
      wire dly = c[`ASCDH_BDLY];
      wire [9:0] fa = {7'h00, nds} * {4'h0, sb} + {5'h00, ndb} + {9'h000, dly};
      wire [9:0] fp = (fa >= tot) ? fa - tot : fa;
      wire [1:0] fw = c[`ASCDH_FSW];
      wire fsd = (fw == `ASCDH_FS_HALF) ? (fp >= {1'b0, tot[9:1]}) :
                 (fw == `ASCDH_FS_BIT) ? (fp == 10'h000) : (fp < {4'h0, sb});
      wire st = (fw == `ASCDH_FS_HALF) ? (fsp_q & ~f2_q) : (~fsp_q & f2_q);

      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mc_q <= 8'h00;
          mck_q <= 1'b0;
          bc_q <= 8'h00;
          sck_q <= 1'b0;
          ds_q <= 3'h0;
          db_q <= 5'h00;
          fs_q <= 1'b0;
          fsp_q <= 1'b0;
          k1_q <= 1'b0;
          k2_q <= 1'b0;
          k3_q <= 1'b0;
          f1_q <= 1'b0;
          f2_q <= 1'b0;
        end else begin
          k1_q <= bit_clock_pin_i[g];
          k2_q <= k1_q;
          k3_q <= k2_q;
          f1_q <= frame_sync_pin_i[g];
          f2_q <= f1_q;
          if (mst & en) begin
            mc_q <= nmc;
            mck_q <= c[`ASCDH_MASTER_CLOCK_OUT_ENABLE] & (nmc <= {1'b0, od[7:1]});
            if (bt) begin
              bc_q <= (bc_q >= bd) ? 8'h00 : bc_q + 8'h01;
            end
          end else begin
            mc_q <= 8'h00;
            mck_q <= 1'b0;
            bc_q <= 8'h00;
          end
          if (!(mst & en)) begin
            sck_q <= 1'b0;
          end else if (rise) begin
            sck_q <= 1'b1;
          end else if (fall) begin
            sck_q <= 1'b0;
          end
          if (fall) begin
            db_q <= ndb;
            ds_q <= nds;
            if (mst) begin
              fs_q <= fsd;
            end
          end
          if (rise & ~mst) begin
            fsp_q <= f2_q;
            if (st) begin
              ds_q <= dly ? c[`ASCDH_NSLOT] : 3'h0;
              db_q <= dly ? sb[4:0] - 5'h01 : 5'h00;
            end
          end
        end
      end

      assign rise_w[g] = rise;
      assign fall_w[g] = fall;
      assign ds_w[3*g+:3] = ds_q;
      assign nds_w[3*g+:3] = nds;
      assign db_w[5*g+:5] = db_q;
      assign ndb_w[5*g+:5] = ndb;
      assign sb_w[6*g+:6] = sb;
      assign master_clock_out_o[g] = mck_q;
      assign bit_clock_pin_o[g] = sck_q;
      assign bit_clock_pin_oe_n_o[g] = ~mst;
      assign frame_sync_pin_o[g] = fs_q;
      assign frame_sync_pin_oe_n_o[g] = ~mst;
    end
  endgenerate

  // ==========================================
  // Transmit serializer, always on unit 0
  wire [2:0] tk = txc_q[`ASCDH_WLEN];
  wire [5:0] twl = wlen(tk);
  wire tcp = (tk == `ASCDH_WL_C16) | (tk == `ASCDH_WL_C8);
  wire [4:0] tsh = (tk == `ASCDH_WL_C16) ? 5'h10 : 5'h08;
  wire txon = ctrl_q[`ASCDH_TXEN] & ctrl_q[`ASCDH_CKEN0] & ~ctl;
  wire [2:0] tds = nds_w[2:0];
  wire [4:0] tdb = ndb_w[4:0];
  wire tld = txon & fall_w[0] & (tdb == 5'h00) & ~(tcp & tds[0]);
  wire [31:0] tfw = txfull_q ? txh_q : (txc_q[`ASCDH_REPEAT] ? last_q[tds] : 32'h0);
  wire [31:0] tw = tld ? tfw : tw_q;
  wire [31:0] tsm = (tcp & tds[0]) ? tw >> tsh : tw;
  wire tin = {1'b0, tdb} < twl;
  wire [5:0] tix = twl - 6'h01 - {1'b0, tdb};
  wire tb = tin ? tsm[tix[4:0]] : txc_q[`ASCDH_EXT];

  // ==========================================
  // Receive serializer, unit selectable
  wire rsel = ctrl_q[`ASCDH_RXCU];
  wire rck = rsel ? ctrl_q[`ASCDH_CKEN1] : ctrl_q[`ASCDH_CKEN0];
  wire rxon = ctrl_q[`ASCDH_RXEN] & rck & ~ctl;
  wire rr = rxon & (rsel ? rise_w[1] : rise_w[0]);
  wire [2:0] rds = rsel ? ds_w[5:3] : ds_w[2:0];
  wire [4:0] rdb = rsel ? db_w[9:5] : db_w[4:0];
  wire [5:0] rsb = rsel ? sb_w[11:6] : sb_w[5:0];
  wire [2:0] rk = rxc_q[`ASCDH_WLEN];
  wire [5:0] rwl = wlen(rk);
  wire rcp = (rk == `ASCDH_WL_C16) | (rk == `ASCDH_WL_C8);
  wire [4:0] rsh = (rk == `ASCDH_WL_C16) ? 5'h10 : 5'h08;
  wire [31:0] rb = (rdb == 5'h00) ? {32{rxc_q[`ASCDH_EXT]}} : rs_q;
  wire rin = {1'b0, rdb} < rwl;
  wire [5:0] rix = rwl - 6'h01 - {1'b0, rdb};
  wire [31:0] rn = rin ? setb(rb, rix, r2_q) : rb;
  wire [31:0] rm = rn & ~(32'hFFFFFFFF << rwl);
  wire rlast = {1'b0, rdb} == rsb - 6'h01;
  wire rdl = rr & rlast & ~(rcp & ~rds[0]);
  wire [31:0] rv = rcp ? ((rm << rsh) | rlo_q) : rm;

  // ==========================================
  // Datapath and flags
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tw_q <= 32'h0;
      rs_q <= 32'h0;
      rlo_q <= 32'h0;
      rxh_q <= 32'h0;
      txh_q <= 32'h0;
      txfull_q <= 1'b0;
      rxrdy_q <= 1'b0;
      rxor_q <= 1'b0;
      txur_q <= 1'b0;
      tx_data_o <= 1'b0;
      r1_q <= 1'b0;
      r2_q <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        last_q[i] <= 32'h0;
      end
    end else begin
      r1_q <= rx_data_i;
      r2_q <= r1_q;
      if (tld) begin
        tw_q <= tfw;
        last_q[tds] <= tfw;
      end
      if (!txon) begin
        tx_data_o <= 1'b0;
      end else if (fall_w[0]) begin
        tx_data_o <= tb;
      end
      if (wr_txd) begin
        txh_q <= reg_wdata_i;
      end
      txfull_q <= wr_txd | (txfull_q & ~tld);
      txur_q <= (tld & ~txfull_q) |
                (txur_q & ~(wr_flag & reg_wdata_i[`ASCDH_F_TXUR]));
      if (rr) begin
        rs_q <= rn;
      end
      if (rr & rlast & rcp & ~rds[0]) begin
        rlo_q <= rm;
      end
      if (rdl) begin
        rxh_q <= rv;
      end
      rxrdy_q <= rdl | (rxrdy_q & ~rd_rxd);
      rxor_q <= (rdl & rxrdy_q & ~rd_rxd) |
                (rxor_q & ~(wr_flag & reg_wdata_i[`ASCDH_F_RXOR]));
    end
  end

  // ==========================================
  // Register port
  always @* begin
    case (reg_addr_i)
      `ASCDH_A_CTRL: rdata_d = ctrl_q;
      `ASCDH_A_CU0: rdata_d = cu0_q;
      `ASCDH_A_CU1: rdata_d = cu1_q;
      `ASCDH_A_TXC: rdata_d = txc_q;
      `ASCDH_A_RXC: rdata_d = rxc_q;
      `ASCDH_A_FLAG: rdata_d = {28'h0, txur_q, ~txfull_q, rxor_q, rxrdy_q};
      `ASCDH_A_RXD: rdata_d = rxh_q;
      default: rdata_d = 32'h0;
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 32'h0;
      cu0_q <= `ASCDH_CU_RST;
      cu1_q <= `ASCDH_CU_RST;
      txc_q <= `ASCDH_SC_RST;
      rxc_q <= `ASCDH_SC_RST;
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 32'h0;
      if (reg_wr_i) begin
        case (reg_addr_i)
          `ASCDH_A_CTRL: ctrl_q <= reg_wdata_i;
          `ASCDH_A_CU0: cu0_q <= reg_wdata_i;
          `ASCDH_A_CU1: cu1_q <= reg_wdata_i;
          `ASCDH_A_TXC: txc_q <= reg_wdata_i;
          `ASCDH_A_RXC: rxc_q <= reg_wdata_i;
          default: ;
        endcase
      end
    end
  end

endmodule

// ===== ascdh_map.vh
`ifndef ASCDH_MAP_VH
`define ASCDH_MAP_VH

// ==========================================
// Register offsets
`define ASCDH_A_CTRL 5'h00
`define ASCDH_A_CU0 5'h04
`define ASCDH_A_CU1 5'h08
`define ASCDH_A_TXC 5'h0C
`define ASCDH_A_RXC 5'h10
`define ASCDH_A_FLAG 5'h14
`define ASCDH_A_RXD 5'h18
`define ASCDH_A_TXD 5'h1C

// ==========================================
// Main control fields
`define ASCDH_MODE 1:0
`define ASCDH_CKEN0 2
`define ASCDH_CKEN1 3
`define ASCDH_TXEN 4
`define ASCDH_RXEN 5
`define ASCDH_RXCU 6
`define ASCDH_M_SLAVE 2'h0
`define ASCDH_M_CTRL 2'h2

// ==========================================
// Clock unit control fields
`define ASCDH_NSLOT 2:0
`define ASCDH_SLSZ 5:4
`define ASCDH_BDLY 6
`define ASCDH_FSW 9:8
`define ASCDH_MASTER_CLOCK_OUT_ENABLE 12
`define ASCDH_MASTER_CLOCK_SOURCE_SELECT 13
`define ASCDH_BIT_CLOCK_SOURCE_SELECT 14
`define ASCDH_BDIV 23:16
`define ASCDH_ODIV 31:24
`define ASCDH_FS_HALF 2'h1
`define ASCDH_FS_BIT 2'h2

// ==========================================
// Serializer control fields and codes
`define ASCDH_WLEN 2:0
`define ASCDH_REPEAT 3
`define ASCDH_EXT 4
`define ASCDH_WL_C16 3'h5
`define ASCDH_WL_C8 3'h7

// ==========================================
// Flag bits and reset values
`define ASCDH_F_RXRDY 0
`define ASCDH_F_RXOR 1
`define ASCDH_F_TXUR 3
`define ASCDH_CU_RST 32'h00030151
`define ASCDH_SC_RST 32'h00000004
`endif

// ===== ascdh_chk_checker.sv
`timescale 1ns/100ps
`include "ascdh_map.vh"
module ascdh_chk (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [4:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire [1:0] master_clock_out_o,
  input wire [1:0] bit_clock_pin_o,
  input wire [1:0] bit_clock_pin_oe_n_o,
  input wire [1:0] frame_sync_pin_o,
  input wire [1:0] frame_sync_pin_oe_n_o,
  input wire tx_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ======
  // Shadows and clock counters
  logic [1:0] md_q;
  logic [31:0] cu_q;
  logic [7:0] per_q;
  logic [9:0] bit_q;
  logic bck_q, fs_q, live_q;
  wire wr_ctl = reg_wr_i && reg_addr_i == `ASCDH_A_CTRL;
  wire wr_cu = reg_wr_i && reg_addr_i == `ASCDH_A_CU0;
  wire bck_up = bit_clock_pin_o[0] && !bck_q;
  wire fs_dn = !frame_sync_pin_o[0] && fs_q;
  wire slv = md_q == `ASCDH_M_SLAVE;
  wire [7:0] bdiv = (cu_q[`ASCDH_BDIV] == 8'h00) ? 8'h01 : cu_q[`ASCDH_BDIV];
  wire [9:0] fbits = 10'((cu_q[`ASCDH_NSLOT] + 1) * (cu_q[`ASCDH_SLSZ] + 1) * 8);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_q <= 2'h0;
      cu_q <= `ASCDH_CU_RST;
      per_q <= 8'h00;
      bit_q <= 10'h000;
      bck_q <= 1'b0;
      fs_q <= 1'b0;
      live_q <= 1'b0;
    end else begin
      if (wr_ctl) md_q <= reg_wdata_i[`ASCDH_MODE];
      if (wr_cu) cu_q <= reg_wdata_i;
      per_q <= bck_up ? 8'h01 : per_q + 8'h01;
      bit_q <= fs_dn ? 10'h000 : bit_q + {9'h000, bck_up};
      bck_q <= bit_clock_pin_o[0];
      fs_q <= frame_sync_pin_o[0];
      live_q <= (wr_ctl || wr_cu) ? 1'b0 : (live_q || fs_dn);
    end
  end
  sequence mck_low_high;
    !master_clock_out_o[0] ##1 master_clock_out_o[0];
  endsequence
  slave_idle_a: assert property (bit_clock_pin_oe_n_o[0] |-> !bit_clock_pin_o[0])
    else $error("bit clock driven in slave");
  pin_dir_a: assert property ({bit_clock_pin_oe_n_o, frame_sync_pin_oe_n_o} == {4{slv}})
    else $error("pin direction wrong");
  mck_gate_a: assert property (!cu_q[`ASCDH_MASTER_CLOCK_OUT_ENABLE] || slv |-> !master_clock_out_o[0])
    else $error("master clock not gated");
  mck_div_a: assert property ($rose(master_clock_out_o[0]) && cu_q[`ASCDH_ODIV] == 8'h01
    |=> mck_low_high) else $error("master clock period");
  bck_div_a: assert property (bck_up && live_q && !cu_q[`ASCDH_MASTER_CLOCK_SOURCE_SELECT]
    && !cu_q[`ASCDH_BIT_CLOCK_SOURCE_SELECT] |-> per_q == bdiv + 8'h01) else $error("bit clock period");
  frame_len_a: assert property (fs_dn && live_q |-> bit_q == fbits)
    else $error("frame length");
  ctrl_tx_off_a: assert property (md_q == `ASCDH_M_CTRL |-> !tx_data_o)
    else $error("data sent in controller mode");
  edge_phase_a: assert property ($changed(tx_data_o) || $changed(frame_sync_pin_o[0])
    |-> !bit_clock_pin_o[0]) else $error("change while bit clock high");
endmodule

// ===== ascdh_codec.sv
`timescale 1ns/100ps
module ascdh_codec #(
  parameter logic [15:0] LEFT_W = 16'hA5C3,
  parameter logic [15:0] RIGHT_W = 16'h5A3C
) (
  input wire bck_i,
  input wire fs_i,
  input wire sd_i,
  output logic sd_o = 1'b0,
  output logic [15:0] left_o = 16'h0000,
  output logic [15:0] right_o = 16'h0000
);
  logic [4:0] cnt_q = 5'h00;
  logic [15:0] cap_q = 16'h0000;
  logic fs_q = 1'b0;
  // ======
  // Capture on rise, drive on fall
  always @(posedge bck_i) cap_q <= {cap_q[14:0], sd_i};
  // Let sync settle: it changes in the same step as the clock fall
  always @(negedge bck_i) begin
    automatic logic [4:0] c;
    automatic logic [15:0] w;
    #1;
    c = (fs_i != fs_q) ? 5'h00 : cnt_q + 5'h01;
    w = (fs_i ^ (c == 5'h00)) ? RIGHT_W : LEFT_W;
    cnt_q <= c;
    fs_q <= fs_i;
    sd_o <= w[4'(5'h10 - c)];
    if (c == 5'h01 && fs_i) left_o <= cap_q;
    if (c == 5'h01 && !fs_i) right_o <= cap_q;
  end
endmodule

// ===== ascdh_tb_top.sv
`timescale 1ns/100ps
`include "ascdh_map.vh"
module ascdh_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] v;
  wire [31:0] reg_rdata_o;
  wire [1:0] mck, bck, bck_oe_n, fs, fs_oe_n;
  wire tx_data_o, rx_data_i;
  wire [15:0] lw, rw;
  int errors = 0;
  int checks = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  ascdh_top DUT (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .master_clock_out_o(mck), .bit_clock_pin_i(2'b00), .bit_clock_pin_o(bck),
    .bit_clock_pin_oe_n_o(bck_oe_n), .frame_sync_pin_i(2'b00), .frame_sync_pin_o(fs),
    .frame_sync_pin_oe_n_o(fs_oe_n), .tx_data_o, .rx_data_i);
  ascdh_codec codec (.bck_i(bck[0]), .fs_i(fs[0]), .sd_i(tx_data_o), .sd_o(rx_data_i),
    .left_o(lw), .right_o(rw));
  // ======
  // Bus tasks and checks
  task end_of_test(input bit t);
    errors += t;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task rd(input logic [4:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_o;
    @(posedge ref_clk_i);
  endtask
  task wfs(input logic b);
    int i;
    for (i = 0; i < 300 && fs[0] !== b; i++) @(posedge ref_clk_i);
    if (i == 300) end_of_test(1'b1);
  endtask
  task frames(input int n);
    repeat (n) begin
      wfs(1'b1);
      wfs(1'b0);
    end
  endtask
  task wflag(input int b);
    int i;
    v = 32'h00000000;
    for (i = 0; i < 200 && v[b] !== 1'b1; i++) rd(`ASCDH_A_FLAG, v);
    if (i == 200) end_of_test(1'b1);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk("pin dir", 32'h3, {30'h0, bck_oe_n});
    rd(`ASCDH_A_CU0, v);
    chk("unit reset", `ASCDH_CU_RST, v);
    rd(`ASCDH_A_TXD, v);
    chk("tx read", 32'h0, v);
    rd(5'h02, v);
    chk("unmapped", 32'h0, v);
    wr(`ASCDH_A_CU0, 32'h01071151);
    wr(`ASCDH_A_TXC, 32'h0000000C);
    wr(`ASCDH_A_RXC, 32'h00000005);
    wr(`ASCDH_A_CTRL, 32'h00000036);
    frames(2);
    chk("pin dir", 32'h0, {30'h0, bck_oe_n});
    rd(`ASCDH_A_FLAG, v);
    chk("rx ready", 32'h0, v & 32'h1);
    wr(`ASCDH_A_CTRL, 32'h00000035);
    frames(1);
    wfs(1'b1);
    wr(`ASCDH_A_TXD, 32'h0000C3A5);
    rd(`ASCDH_A_FLAG, v);
    chk("tx ready", 32'h0, v & 32'h4);
    wflag(2);
    wr(`ASCDH_A_TXD, 32'h0000E718);
    frames(3);
    chk("left word", 32'h0000E718, {16'h0, lw});
    chk("right word", 32'h0000C3A5, {16'h0, rw});
    rd(`ASCDH_A_FLAG, v);
    chk("underrun", 32'h8, v & 32'h8);
    wr(`ASCDH_A_FLAG, 32'h00000008);
    rd(`ASCDH_A_FLAG, v);
    chk("underrun clr", 32'h0, v & 32'h8);
    wr(`ASCDH_A_TXC, 32'h00000004);
    frames(3);
    chk("left zero", 32'h0, {16'h0, lw});
    chk("right zero", 32'h0, {16'h0, rw});
    rd(`ASCDH_A_RXD, v);
    wflag(0);
    rd(`ASCDH_A_RXD, v);
    chk("rx word", 32'h5A3CA5C3, v);
    rd(`ASCDH_A_FLAG, v);
    chk("rx ready clr", 32'h0, v & 32'h1);
    frames(2);
    wfs(1'b1);
    rd(`ASCDH_A_FLAG, v);
    chk("overrun", 32'h3, v & 32'h3);
    wr(`ASCDH_A_FLAG, 32'h00000002);
    rd(`ASCDH_A_FLAG, v);
    chk("overrun clr", 32'h1, v & 32'h3);
    end_of_test(1'b0);
  end
endmodule
bind ascdh_top ascdh_chk u_chk (.*);
